/* pkg/motor_pwm_regs.svh */
`ifndef MOTOR_PWM_REGS_SVH
`define MOTOR_PWM_REGS_SVH
`define OFF_CTRL0 8'h00
`define OFF_CTRL1 8'h04
`define OFF_PROT 8'h08
`define OFF_SPEC 8'h0c
`define OFF_PERIOD 8'h10
`define OFF_IRQCNT 8'h14
`define OFF_DEAD 8'h18
`define OFF_WU 8'h1c
`define OFF_WV 8'h20
`define OFF_WW 8'h24
`define OFF_AU 8'h28
`define OFF_AV 8'h2c
`define OFF_AW 8'h30
`define OFF_BUF0 8'h34
`define OFF_BUF1 8'h38
`define OFF_PORT 8'h3c
`define OFF_STAT 8'h40
`define B_ITS 0
`define B_CMS 1
`define B_FEN 2
`define B_OEN 3
`define B_CAD 4
`define B_CAF 5
`define B_SAW 6
`define B_STT 7
`define B_CWT 0
`define B_DWM 1
`define B_DTD 2
`define B_ACT 3
`define B_RUN 4
`define F_CSRC 6:5
`define F_DSRC 8:7
`define B_WPR 1
`define B_CRS 0
`define B_CUT 1
`define CTRL0_RST 8'h00
`define CTRL1_RST 9'h000
`endif

/* pkg/motor_pwm_pkg.sv */
package motor_pwm_pkg;
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avs_req_s;
    typedef enum logic [1:0] {
        SRC_F1 = 2'b00,
        SRC_F2 = 2'b01,
        SRC_F8 = 2'b10,
        SRC_F32 = 2'b11
    } csrc_e;
    typedef enum logic [1:0] {
        DSRC_F1 = 2'b00,
        DSRC_F2 = 2'b01,
        DSRC_F1H = 2'b10,
        DSRC_F2H = 2'b11
    } dsrc_e;
endpackage

/* rtl/three_phase_motor_pwm.sv */
`timescale 1ns/1ps
`include "motor_pwm_regs.svh"
module three_phase_motor_pwm (
    input wire logic mclk,
    input wire logic rstn,
    input wire motor_pwm_pkg::avs_req_s avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cutoff_n,
    output logic [5:0] phase_out,
    output logic [5:0] phase_oe_n,
    output logic carrier_irq
);
    logic ack;
    logic [7:0] ctrl0;
    logic [8:0] ctrl1;
    logic wpr;
    logic crs;
    logic cut_en;
    logic [15:0] period;
    logic [15:0] cper;
    logic [3:0] irq_n;
    logic [7:0] dead;
    logic [15:0] width [3];
    logic [15:0] alt [3];
    logic [5:0] buf0;
    logic [5:0] buf1;
    logic [5:0] pdir;
    logic [5:0] pdat;
    logic [4:0] div;
    logic [15:0] ccnt;
    logic half;
    logic [16:0] pcnt [3];
    logic [2:0] alt_sel;
    logic bw0;
    logic bw1;
    logic [5:0] st0;
    logic [5:0] st1;
    logic [5:0] raw;
    logic [5:0] raw_q;
    logic [2:0] sel;
    logic [7:0] dt [3];
    logic [3:0] icnt;
    logic cut_s1;
    logic cut_s2;
    logic cut_s3;
    logic cut_lat;
    logic tick;
    logic dtick;
    logic uflow;
    logic trig;
    logic xfer;
    logic [2:0] pulse;
    logic [2:0] fall;
    logic [5:0] act;
    logic [5:0] safe;
    logic [2:0] both;
    logic conc;

    wire wr = avs_req.write & ack;
    wire [7:0] adr = avs_req.address;
    wire [31:0] wd = avs_req.writedata;
    wire [3:0] be = avs_req.byteenable;
    wire fen = ctrl0[`B_FEN];
    wire saw = ctrl0[`B_SAW];
    wire run = ctrl1[`B_RUN];
    wire dwm = ctrl1[`B_DWM];
    wire cut_fall = cut_s3 & ~cut_s2;

    // Byte lane merge for the 16-bit registers
    function automatic logic [15:0] m16(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] b);
        m16 = {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
    endfunction

    // Write strobe for one register, either of the two low byte lanes required
    function automatic logic hit(input logic w, input logic [7:0] a, input logic [7:0] off,
                                 input logic [3:0] b);
        hit = w & (a == off) & (b[0] | b[1]);
    endfunction

    // Count source tick from the free prescaler
    function automatic logic csel(input logic [1:0] s, input logic [4:0] d);
        case (motor_pwm_pkg::csrc_e'(s))
            motor_pwm_pkg::SRC_F1: csel = 1'b1;
            motor_pwm_pkg::SRC_F2: csel = d[0];
            motor_pwm_pkg::SRC_F8: csel = &d[2:0];
            default: csel = &d;
        endcase
    endfunction

    // One wait state: answer lands one edge after the request appears
    assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_req.read | avs_req.write) & ~ack;
        end
    end

    // Read mux, sampled in the wait cycle so data stands at the ack edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_req.read & ~ack) begin
            case (adr)
                `OFF_CTRL0: avs_readdata <= {24'h000000, 1'b0, ctrl0[6:0]};
                `OFF_CTRL1: avs_readdata <= {23'h000000, ctrl1};
                `OFF_PROT: avs_readdata <= {30'h00000000, wpr, 1'b0};
                `OFF_SPEC: avs_readdata <= {30'h00000000, cut_en, crs};
                `OFF_PERIOD: avs_readdata <= {16'h0000, period};
                `OFF_IRQCNT: avs_readdata <= {28'h0000000, irq_n};
                `OFF_DEAD: avs_readdata <= {24'h000000, dead};
                `OFF_WU: avs_readdata <= {16'h0000, width[0]};
                `OFF_WV: avs_readdata <= {16'h0000, width[1]};
                `OFF_WW: avs_readdata <= {16'h0000, width[2]};
                `OFF_AU: avs_readdata <= {16'h0000, alt[0]};
                `OFF_AV: avs_readdata <= {16'h0000, alt[1]};
                `OFF_AW: avs_readdata <= {16'h0000, alt[2]};
                `OFF_BUF0: avs_readdata <= {26'h0000000, buf0};
                `OFF_BUF1: avs_readdata <= {26'h0000000, buf1};
                `OFF_PORT: avs_readdata <= {18'h00000, pdat, 2'h0, pdir};
                `OFF_STAT: avs_readdata <= {16'h0000, ccnt[7:0], cut_lat, half, ~phase_oe_n};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Motor control register; hardware clears of output enable beat a software set
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl0 <= `CTRL0_RST;
        end else begin
            if (hit(wr, adr, `OFF_CTRL0, be) & wpr) begin
                ctrl0[`B_ITS] <= wd[`B_ITS];
                ctrl0[`B_CMS] <= wd[`B_CMS];
                ctrl0[`B_FEN] <= wd[`B_FEN];
                ctrl0[`B_OEN] <= wd[`B_OEN];
                ctrl0[`B_CAD] <= wd[`B_CAD];
                ctrl0[`B_SAW] <= wd[`B_SAW];
                if (!wd[`B_CAF]) begin
                    ctrl0[`B_CAF] <= 1'b0;
                end
            end
            if (conc) begin
                ctrl0[`B_CAF] <= 1'b1;
            end
            if (cut_fall | (conc & ctrl0[`B_CAD]) | (ctrl0[`B_CAD] & ctrl0[`B_CAF])) begin
                ctrl0[`B_OEN] <= 1'b0;
            end
            ctrl0[`B_STT] <= 1'b0;
        end
    end

    // Second control, protect and special mode registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl1 <= `CTRL1_RST;
            wpr <= 1'b0;
            crs <= 1'b0;
            cut_en <= 1'b0;
        end else begin
            if (hit(wr, adr, `OFF_CTRL1, be) & wpr) begin
                ctrl1 <= wd[8:0];
            end
            if (hit(wr, adr, `OFF_PROT, be)) begin
                wpr <= wd[`B_WPR];
            end
            if (hit(wr, adr, `OFF_SPEC, be) & wpr) begin
                crs <= wd[`B_CRS];
                cut_en <= wd[`B_CUT];
            end
        end
    end

    // Value registers; phase widths, periods and patterns
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            period <= 16'h0000;
            irq_n <= 4'h1;
            dead <= 8'h00;
            buf0 <= 6'h00;
            buf1 <= 6'h00;
            pdir <= 6'h00;
            pdat <= 6'h00;
            for (int i = 0; i < 3; i++) begin
                width[i] <= 16'h0000;
                alt[i] <= 16'h0000;
            end
        end else begin
            if (hit(wr, adr, `OFF_PERIOD, be)) period <= m16(period, wd, be);
            if (hit(wr, adr, `OFF_IRQCNT, be)) irq_n <= wd[3:0];
            if (hit(wr, adr, `OFF_DEAD, be)) dead <= wd[7:0];
            if (hit(wr, adr, `OFF_WU, be)) width[0] <= m16(width[0], wd, be);
            if (hit(wr, adr, `OFF_WV, be)) width[1] <= m16(width[1], wd, be);
            if (hit(wr, adr, `OFF_WW, be)) width[2] <= m16(width[2], wd, be);
            if (hit(wr, adr, `OFF_AU, be)) alt[0] <= m16(alt[0], wd, be);
            if (hit(wr, adr, `OFF_AV, be)) alt[1] <= m16(alt[1], wd, be);
            if (hit(wr, adr, `OFF_AW, be)) alt[2] <= m16(alt[2], wd, be);
            if (hit(wr, adr, `OFF_BUF0, be)) buf0 <= wd[5:0];
            if (hit(wr, adr, `OFF_BUF1, be)) buf1 <= wd[5:0];
            if (hit(wr, adr, `OFF_PORT, be)) begin
                pdir <= wd[5:0];
                pdat <= wd[13:8];
            end
        end
    end

    // Free prescaler; all slower rates are enables off it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div <= 5'h00;
        end else begin
            div <= div + 5'h01;
        end
    end

    assign tick = csel(ctrl1[`F_CSRC], div);

    // Dead tick: f1, f2, f1 halved, f2 halved
    always_comb begin
        case (motor_pwm_pkg::dsrc_e'(ctrl1[`F_DSRC]))
            motor_pwm_pkg::DSRC_F1: dtick = 1'b1;
            motor_pwm_pkg::DSRC_F2: dtick = div[0];
            motor_pwm_pkg::DSRC_F1H: dtick = div[0];
            default: dtick = &div[1:0];
        endcase
    end

    // Carrier timer; two underflows make one triangular carrier cycle
    assign uflow = run & tick & (ccnt == 16'h0000);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ccnt <= 16'h0000;
            cper <= 16'h0000;
            half <= 1'b0;
        end else if (!run) begin
            ccnt <= period;
            cper <= period;
            half <= 1'b0;
        end else if (uflow) begin
            // Reload on every underflow, or only at the end of a full triangle
            if (!crs | half) begin
                ccnt <= period;
                cper <= period;
            end else begin
                ccnt <= cper;
            end
            half <= ~half;
        end else if (tick) begin
            ccnt <= ccnt - 16'h0001;
        end
    end

    // One-shot phase timers started by each carrier underflow
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            alt_sel <= 3'h0;
            for (int i = 0; i < 3; i++) pcnt[i] <= 17'h00000;
        end else if (!run) begin
            alt_sel <= 3'h0;
            for (int i = 0; i < 3; i++) pcnt[i] <= 17'h00000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (uflow) begin
                    // Zero width starts nothing
                    if (dwm & ~alt_sel[i]) begin
                        pcnt[i] <= saw ? {1'b0, alt[i]} : {alt[i], 1'b0};
                    end else begin
                        pcnt[i] <= saw ? {1'b0, width[i]} : {width[i], 1'b0};
                    end
                    alt_sel[i] <= dwm & ~alt_sel[i];
                end else if (tick & (pcnt[i] != 17'h00000)) begin
                    pcnt[i] <= pcnt[i] - 17'h00001;
                end
            end
        end
    end

    // Pulse ends on the tick that empties the one-shot; a delayed edge would add a tick
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pulse[i] = pcnt[i] == 17'h00001;
            fall[i] = run & tick & ~uflow & pulse[i];
        end
    end

    // Transfer trigger and buffer-written tracking; a write beats the clear
    assign trig = uflow | (hit(wr, adr, `OFF_CTRL0, be) & wpr & wd[`B_STT])
                | (hit(wr, adr, `OFF_PERIOD, be) & ctrl1[`B_CWT]);
    assign xfer = trig & (saw | (bw0 & bw1));

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bw0 <= 1'b0;
            bw1 <= 1'b0;
            st0 <= 6'h00;
            st1 <= 6'h00;
        end else begin
            if (xfer) begin
                bw0 <= 1'b0;
                bw1 <= 1'b0;
                st0 <= buf0;
                st1 <= buf1;
            end
            if (hit(wr, adr, `OFF_BUF0, be)) bw0 <= 1'b1;
            if (hit(wr, adr, `OFF_BUF1, be)) bw1 <= 1'b1;
        end
    end

    // Phase pattern: first stage first, second stage at the pulse fall
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            raw <= 6'h00;
            sel <= 3'h0;
        end else if (!fen) begin
            raw <= 6'h00;
            sel <= 3'h0;
        end else begin
            if (xfer) begin
                sel <= saw ? 3'h7 : 3'h0;
                if (saw) raw <= buf0;
            end
            for (int i = 0; i < 3; i++) begin
                if (fall[i] & ~(xfer & saw)) begin
                    raw[2*i +: 2] <= sel[i] ? st1[2*i +: 2] : st0[2*i +: 2];
                    sel[i] <= saw | ~sel[i];
                end
            end
        end
    end

    // Dead timers: a phase turning active waits out the shared reload value
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            raw_q <= 6'h00;
            for (int i = 0; i < 3; i++) dt[i] <= 8'h00;
        end else begin
            raw_q <= raw;
            for (int i = 0; i < 3; i++) begin
                if (!fen | ctrl1[`B_DTD]) begin
                    dt[i] <= 8'h00;
                end else if (raw[2*i +: 2] != raw_q[2*i +: 2]) begin
                    dt[i] <= dead;
                end else if (dtick & (dt[i] != 8'h00)) begin
                    dt[i] <= dt[i] - 8'h01;
                end
            end
        end
    end

    // Gate by dead time, then detect and block both sides active
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            act[2*i +: 2] = (ctrl1[`B_DTD] | ((dt[i] == 8'h00)
                            & (raw[2*i +: 2] == raw_q[2*i +: 2]))) ? raw[2*i +: 2] : 2'b00;
            both[i] = &act[2*i +: 2];
            safe[2*i +: 2] = (both[i] & ctrl0[`B_CAD]) ? 2'b00 : act[2*i +: 2];
        end
    end
    assign conc = |both;

    // Cutoff pin synchroniser and latched cutoff, released only with enable off
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cut_s1 <= 1'b1;
            cut_s2 <= 1'b1;
            cut_s3 <= 1'b1;
            cut_lat <= 1'b0;
        end else begin
            cut_s1 <= cutoff_n;
            cut_s2 <= cut_s1;
            cut_s3 <= cut_s2;
            if (cut_en & ~cut_s2) begin
                cut_lat <= 1'b1;
            end else if (~cut_en & cut_s2) begin
                cut_lat <= 1'b0;
            end
        end
    end

    // Pin drive: PWM, port function, or high impedance
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_out <= 6'h00;
            phase_oe_n <= 6'h3f;
        end else if (cut_lat | (cut_en & ~cut_s2)) begin
            phase_oe_n <= 6'h3f;
        end else if (fen & ctrl0[`B_OEN]) begin
            phase_out <= ctrl1[`B_ACT] ? safe : ~safe;
            phase_oe_n <= 6'h00;
        end else begin
            phase_out <= pdat;
            phase_oe_n <= ~pdir;
        end
    end

    // Carrier interrupt decimation; preset of one gives the short first period
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            icnt <= 4'h0;
            carrier_irq <= 1'b0;
        end else begin
            carrier_irq <= 1'b0;
            if (!fen | !run) begin
                icnt <= (dwm & ctrl0[`B_ITS]) ? 4'h1 : 4'h0;
            end else if (uflow & (~(dwm & ctrl0[`B_CMS]) | half)) begin
                if (icnt + 4'h1 >= irq_n) begin
                    icnt <= 4'h0;
                    carrier_irq <= 1'b1;
                end else begin
                    icnt <= icnt + 4'h1;
                end
            end
        end
    end
endmodule

/* tb/motor_pwm_properties.sv */
`timescale 1ns/1ps
`include "motor_pwm_regs.svh"
module motor_pwm_properties (
    input wire logic mclk,
    input wire logic rstn,
    input wire motor_pwm_pkg::avs_req_s avs_req,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cutoff_n,
    input wire logic [5:0] phase_out,
    input wire logic [5:0] phase_oe_n,
    input wire logic carrier_irq
);
    logic prot;
    logic fen;
    logic cad;
    logic acth;
    logic cut_en;
    logic wr_ok;
    logic req;
    logic [5:0] drv;
    assign req = avs_req.read || avs_req.write;
    assign wr_ok = avs_req.write && !avs_waitrequest && avs_req.byteenable[0];
    assign drv = phase_out & ~phase_oe_n;
    // Shadow of software-owned mode bits; hardware never changes these
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prot <= 1'b0;
            fen <= 1'b0;
            cad <= 1'b0;
            acth <= 1'b0;
            cut_en <= 1'b0;
        end else if (wr_ok) begin
            if (avs_req.address == `OFF_PROT) begin
                prot <= avs_req.writedata[`B_WPR];
            end
            if (prot && avs_req.address == `OFF_CTRL0) begin
                fen <= avs_req.writedata[`B_FEN];
                cad <= avs_req.writedata[`B_CAD];
            end
            if (prot && avs_req.address == `OFF_CTRL1) begin
                acth <= avs_req.writedata[`B_ACT];
            end
            if (prot && avs_req.address == `OFF_SPEC) begin
                cut_en <= avs_req.writedata[`B_CUT];
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    AST_ONE_WAIT: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    AST_ACK_SINGLE: assert property (req && !avs_waitrequest |=> avs_waitrequest || !req)
        else $error("waitrequest low for more than one cycle");
    AST_READ_HOLD: assert property (!avs_req.read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    AST_UNMAPPED_ZERO: assert property (
        avs_req.read && !avs_waitrequest && avs_req.address > `OFF_STAT |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RESET_HIZ: assert property ($rose(rstn) |-> phase_oe_n == 6'h3f && !carrier_irq)
        else $error("pins driven right after reset");
    AST_CUTOFF_HIZ: assert property ((cut_en && !cutoff_n) [*4] |-> phase_oe_n == 6'h3f)
        else $error("cutoff did not release the pins");
    AST_NO_OVERLAP: assert property (
        fen && cad && acth |-> (drv & (drv >> 1) & 6'h15) == 6'h00)
        else $error("both switches of a leg active");
    AST_IRQ_NEEDS_FEN: assert property (!fen [*2] |-> !carrier_irq)
        else $error("carrier interrupt with function off");
endmodule
bind three_phase_motor_pwm motor_pwm_properties i_props (
    .mclk(mclk),
    .rstn(rstn),
    .avs_req(avs_req),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cutoff_n(cutoff_n),
    .phase_out(phase_out),
    .phase_oe_n(phase_oe_n),
    .carrier_irq(carrier_irq)
);

/* tb/gate_driver_model.sv */
`timescale 1ns/1ps
module gate_driver_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [5:0] phase_out,
    input wire logic [5:0] phase_oe_n,
    input wire logic fault_req,
    output logic cutoff_n,
    output logic [5:0] gate,
    output logic [7:0] shoot_count
);
    // Open-drain fault line with pull-up, high once released
    assign cutoff_n = !fault_req;
    // Gate inputs are pulled down, so a floating pin means switch off
    assign gate = phase_out & ~phase_oe_n;
    // Shoot-through counter; assumes active-high gates only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shoot_count <= 8'h00;
        end else if ((gate & (gate >> 1) & 6'h15) != 6'h00) begin
            shoot_count <= shoot_count + 8'h01;
        end
    end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "motor_pwm_regs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
    typedef struct {logic [31:0] ctrl1; logic [31:0] ctrl0; logic [31:0] irqn; int gap;} row_s;
    logic mclk;
    logic rstn;
    motor_pwm_pkg::avs_req_s req;
    logic [31:0] rdata;
    logic wait_req;
    logic cut_n;
    logic [5:0] pout;
    logic [5:0] poe_n;
    logic irq;
    logic fault;
    logic [5:0] gate;
    logic [7:0] shoot;
    logic [31:0] rd;
    int fail_count;
    int total_checks;
    int g;
    row_s rows[5];
    three_phase_motor_pwm i_dut (.mclk(mclk), .rstn(rstn), .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .cutoff_n(cut_n), .phase_out(pout), .phase_oe_n(poe_n),
        .carrier_irq(irq));
    gate_driver_model i_bridge (.mclk(mclk), .rstn(rstn), .phase_out(pout), .phase_oe_n(poe_n),
        .fault_req(fault), .cutoff_n(cut_n), .gate(gate), .shoot_count(shoot));
    // Free-running 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One Avalon transfer; request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
        do begin
            @(posedge mclk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        rd = rdata;
        if (wait_req !== 1'b0) begin
            fail_count++;
            summarize();
        end
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    // Cycles between two carrier interrupts, bounded
    task automatic irq_gap;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        g = 0;
        do begin
            @(negedge mclk);
            g++;
        end while (irq !== 1'b1 && g < 1000);
        if (n >= 1000 || g >= 1000) begin
            fail_count++;
            summarize();
        end
    endtask
    initial begin
        rows[0] = '{32'h1c, 32'h4c, 32'h1, 10};
        rows[1] = '{32'h1c, 32'h0c, 32'h1, 10};
        rows[2] = '{32'h1c, 32'h4c, 32'hf, 150};
        rows[3] = '{32'h1c, 32'h0c, 32'h3, 30};
        rows[4] = '{32'h1e, 32'h0f, 32'h2, 40};
        rstn = 1'b0;
        req = '0;
        fault = 1'b0;
        fail_count = 0;
        total_checks = 0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        `CHK(poe_n, 6'h3f)
        bus(1'b0, `OFF_IRQCNT, 32'h0);
        `CHK(rd, 32'h1)
        bus(1'b0, 8'h44, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, `OFF_CTRL0, 32'h04);
        bus(1'b0, `OFF_CTRL0, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, `OFF_PROT, 32'h2);
        bus(1'b1, `OFF_CTRL0, 32'h20);
        bus(1'b0, `OFF_CTRL0, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, `OFF_PERIOD, 32'h9);
        bus(1'b1, `OFF_WU, 32'h3);
        bus(1'b1, `OFF_BUF0, 32'h15);
        bus(1'b1, `OFF_BUF1, 32'h2a);
        $display("reset and protection test done");
        // Interrupt spacing per mode and counter value; timers stopped while changing mode
        foreach (rows[i]) begin
            bus(1'b1, `OFF_CTRL1, rows[i].ctrl1 & ~32'h10);
            bus(1'b1, `OFF_IRQCNT, rows[i].irqn);
            bus(1'b1, `OFF_CTRL0, rows[i].ctrl0);
            bus(1'b1, `OFF_CTRL1, rows[i].ctrl1);
            irq_gap();
            `CHK(g, rows[i].gap)
            $display("row %0d done", i);
        end
        // Sawtooth pulse width over four carrier periods
        bus(1'b1, `OFF_CTRL1, 32'h0c);
        bus(1'b1, `OFF_CTRL0, 32'h4c);
        bus(1'b1, `OFF_IRQCNT, 32'h1);
        bus(1'b1, `OFF_CTRL1, 32'h1c);
        irq_gap();
        `CHK(poe_n, 6'h00)
        g = 0;
        repeat (40) begin
            @(negedge mclk);
            g += (gate[0] === 1'b1);
        end
        `CHK(g, 12)
        $display("width test done");
        // Forced cutoff from the bridge fault line
        bus(1'b1, `OFF_SPEC, 32'h2);
        fault <= 1'b1;
        repeat (5) @(posedge mclk);
        `CHK(poe_n, 6'h3f)
        bus(1'b0, `OFF_CTRL0, 32'h0);
        `CHK(rd[3], 1'b0)
        fault <= 1'b0;
        repeat (4) @(posedge mclk);
        bus(1'b1, `OFF_SPEC, 32'h0);
        `CHK(poe_n, 6'h3f)
        $display("cutoff test done");
        // Overlapping pattern with protection on, then software clear
        bus(1'b1, `OFF_CTRL0, 32'h5c);
        bus(1'b1, `OFF_BUF0, 32'h03);
        irq_gap();
        bus(1'b0, `OFF_CTRL0, 32'h0);
        `CHK(rd[5:3], 3'b110)
        bus(1'b1, `OFF_BUF0, 32'h15);
        irq_gap();
        bus(1'b1, `OFF_CTRL0, 32'h4c);
        bus(1'b0, `OFF_CTRL0, 32'h0);
        `CHK(rd[5:4], 2'b00)
        `CHK(shoot, 8'h00)
        $display("concurrent test done");
        summarize();
    end
endmodule
